/* src/spi_dev_end.sv */
// device end: command decode, register file and serial shifter
// assumes the host keeps mode 3 and opens each access with a command byte
// Notes on behaviour
// R01 - mode 3: drive on fall, sample on rise
// R02 - works with select pin or tied low
// R03 - command register: eight bits, write only
// R04 - after reset first eight bits are command
// R05 - command picks read or write, address
// R06 - after data phase expect new command
// R07 - write data length set by register
// R08 - read shifts 8 to 32 bits out
// R09 - fixed identification register, read only
// R10 - 64 high data bits reset everything
// R11 - select high aborts transfer
// R12 - host resets after power-up or misalignment
// R13 - bit7 enable, bit6 direction, bits5:0 address
// R14 - accept only enable zero; one reads; here enable one drops the command byte and stays in command phase
`timescale 1ns/100ps
module spi_dev_end
	import spi_front_pkg::*;
#(
	parameter logic [15:0] ID_VALUE = 16'h5a5a // arbitrary value
) (
	spi_link_if.dev          link,
	input  wire logic        RESETN_IN,
	input  wire logic [31:0] SAMPLE_IN,
	output logic [7:0]       CTL_OUT,
	output logic [15:0]      CH_CFG_OUT,
	output logic [15:0]      SETUP_OUT,
	output logic [23:0]      OFFSET_OUT
);
	typedef enum logic [1:0] {
		PH_CMD   = 2'b00,
		PH_WRITE = 2'b01,
		PH_READ  = 2'b10
	} phase_type;

	typedef struct packed {
		phase_type   phase;
		logic [5:0]  cnt;
		logic [5:0]  len;
		logic [5:0]  addr;
		logic [31:0] sh;
		logic [31:0] tx;
	} frame_type;

	typedef struct packed {
		logic [7:0]  ctl;
		logic [15:0] ch0;
		logic [15:0] setup0;
		logic [23:0] offs0;
		logic [6:0]  ones;
		logic [31:0] samp_s1;
		logic [31:0] samp_s2;
	} regs_type;

	typedef struct packed {
		logic dout;
		logic oe;
	} drive_type;

	localparam frame_type FRAME_RST = '{
		phase: PH_CMD,
		cnt:   6'd0,
		len:   6'd0,
		addr:  6'd0,
		sh:    32'h0000_0000,
		tx:    32'h0000_0000
	};

	frame_type fq;
	frame_type fd;
	regs_type  rq;
	regs_type  rd;
	drive_type dq;
	drive_type dd;
	logic      frame_rst_n;
	logic [31:0] sh_n;
	logic [5:0]  cmd_addr;
	logic [5:0]  cmd_len;

	// a high select clears the frame at once, whether the clock runs or not
	assign frame_rst_n = RESETN_IN & ~link.cs_n; // see R11 R02
	assign sh_n        = {fq.sh[30:0], link.din};
	assign cmd_addr    = sh_n[5:0]; // see R13
	assign cmd_len     = reg_len(cmd_addr);

	function automatic logic [31:0] read_word(
		input logic [5:0]  addr,
		input regs_type    r
	);
		case (addr)
			ADDR_SAMPLE: read_word = r.samp_s2;
			ADDR_ID:     read_word = {16'h0000, ID_VALUE}; // see R09
			ADDR_CTL:    read_word = {24'h00_0000, r.ctl};
			ADDR_CH0:    read_word = {16'h0000, r.ch0};
			ADDR_SETUP0: read_word = {16'h0000, r.setup0};
			ADDR_OFFS0:  read_word = {8'h00, r.offs0};
			default:     read_word = 32'h0000_0000; // see R03
		endcase
	endfunction

	always_comb begin
		fd = fq;
		rd = rq;
		fd.sh = sh_n;
		fd.tx = {fq.tx[30:0], 1'b0};
		fd.cnt = fq.cnt + 6'd1;
		rd.samp_s1 = SAMPLE_IN;
		rd.samp_s2 = rq.samp_s1;
		case (fq.phase)
			PH_CMD: begin // see R04
				if (fq.cnt == 6'(CMD_BITS - 1)) begin
					fd.cnt = 6'd0;
					if (!sh_n[CMD_WEN_BIT]) begin // see R14
						fd.addr = cmd_addr; // see R05
						fd.len = cmd_len;
						if (sh_n[CMD_RW_BIT]) begin
							fd.phase = PH_READ;
							// left-align so the first falling edge shows the msb
							fd.tx = read_word(cmd_addr, rq) << (6'd32 - cmd_len); // see R08
						end else begin
							fd.phase = PH_WRITE;
						end
					end
				end
			end
			PH_WRITE: begin
				if (fq.cnt == fq.len - 6'd1) begin // see R07
					fd.phase = PH_CMD; // see R06
					fd.cnt = 6'd0;
					case (fq.addr)
						ADDR_CTL:    rd.ctl = sh_n[7:0];
						ADDR_CH0:    rd.ch0 = sh_n[15:0];
						ADDR_SETUP0: rd.setup0 = sh_n[15:0];
						ADDR_OFFS0:  rd.offs0 = sh_n[23:0];
						default:     rd.ctl = rq.ctl;
					endcase
				end
			end
			PH_READ: begin
				if (fq.cnt == fq.len - 6'd1) begin // see R08
					fd.phase = PH_CMD; // see R06
					fd.cnt = 6'd0;
				end
			end
			default: begin
				fd = FRAME_RST;
			end
		endcase
		// long run of high data bits: full reset of frame and registers
		if (link.din) begin
			if (rq.ones == ONES_RESET - 7'd1) begin // see R10
				fd = FRAME_RST;
				rd.ones = 7'd0;
				rd.ctl = RST_CTL;
				rd.ch0 = RST_CH0;
				rd.setup0 = RST_SETUP0;
				rd.offs0 = RST_OFFS0;
			end else begin
				rd.ones = rq.ones + 7'd1;
			end
		end else begin
			rd.ones = 7'd0;
		end
	end

	// sample edge
	always_ff @(posedge link.sclk or negedge frame_rst_n) begin // see R01
		if (!frame_rst_n) begin
			fq <= FRAME_RST;
		end else begin
			fq <= fd;
		end
	end

	always_ff @(posedge link.sclk or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			rq <= '{
				ctl:     RST_CTL,
				ch0:     RST_CH0,
				setup0:  RST_SETUP0,
				offs0:   RST_OFFS0,
				ones:    7'd0,
				samp_s1: 32'h0000_0000,
				samp_s2: 32'h0000_0000
			};
		end else begin
			rq <= rd;
		end
	end

	always_comb begin
		dd.dout = fq.tx[31];
		dd.oe = (fq.phase == PH_READ);
	end

	// drive edge
	always_ff @(negedge link.sclk or negedge frame_rst_n) begin // see R01
		if (!frame_rst_n) begin
			dq <= '{dout: 1'b1, oe: 1'b0};
		end else begin
			dq <= dd;
		end
	end

	assign link.dout    = dq.dout;
	assign link.dout_oe = dq.oe;
	assign CTL_OUT      = rq.ctl;
	assign CH_CFG_OUT   = rq.ch0;
	assign SETUP_OUT    = rq.setup0;
	assign OFFSET_OUT   = rq.offs0;
endmodule

/* src/spi_front_pkg.sv */
// constants shared by both ends of the serial register link
// assumes mode 3 framing: command byte first, then the register data
package spi_front_pkg;
	// command byte layout
	localparam int CMD_WEN_BIT = 7;
	localparam int CMD_RW_BIT  = 6;
	localparam int CMD_BITS    = 8;
	// device register addresses
	localparam logic [5:0] ADDR_CMD    = 6'h00;
	localparam logic [5:0] ADDR_CTL    = 6'h02;
	localparam logic [5:0] ADDR_SAMPLE = 6'h04;
	localparam logic [5:0] ADDR_ID     = 6'h07;
	localparam logic [5:0] ADDR_CH0    = 6'h10;
	localparam logic [5:0] ADDR_SETUP0 = 6'h20;
	localparam logic [5:0] ADDR_OFFS0  = 6'h30;
	// reset values
	localparam logic [7:0]  RST_CTL    = 8'h00;
	localparam logic [15:0] RST_CH0    = 16'h8001;
	localparam logic [15:0] RST_SETUP0 = 16'h1000;
	localparam logic [23:0] RST_OFFS0  = 24'h80_0000;
	// consecutive high data bits that reset the whole device
	localparam logic [6:0] ONES_RESET = 7'd64;
	// host register offsets
	localparam logic [2:0] H_CTRL   = 3'h0;
	localparam logic [2:0] H_DATA   = 3'h1;
	localparam logic [2:0] H_RESET  = 3'h2;
	localparam logic [2:0] H_STATUS = 3'h3;
	localparam logic [2:0] H_MODE   = 3'h4;
	// serial clock timing
	localparam int CLK_PERIOD_NS  = 10;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int HALF_CYCLES    = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

	// data length in bits of each register; unmapped ones take one byte
	function automatic logic [5:0] reg_len(input logic [5:0] addr);
		case (addr)
			ADDR_SAMPLE: reg_len = 6'd32;
			ADDR_ID:     reg_len = 6'd16;
			ADDR_CH0:    reg_len = 6'd16;
			ADDR_SETUP0: reg_len = 6'd16;
			ADDR_OFFS0:  reg_len = 6'd24;
			default:     reg_len = 6'd8;
		endcase
	endfunction
endpackage

/* src/spi_host_end.sv */
// host end: software register port that runs command and reset frames
// assumes the device answers in mode 3 on the shared link
`timescale 1ns/100ps
module spi_host_end
	import spi_front_pkg::*;
#(
	parameter int HALF = HALF_CYCLES
) (
	input  wire logic        MCLK_IN,
	input  wire logic        RESETN_IN,
	input  wire logic [2:0]  ADDR_IN,
	input  wire logic [31:0] WDATA_IN,
	input  wire logic        WR_IN,
	input  wire logic        RD_IN,
	output logic [31:0]      RDATA_OUT,
	output logic             BUSY_OUT,
	spi_link_if.host         link
);
	typedef struct packed {
		logic        busy;
		logic        three_wire;
		logic [7:0]  div;
		logic [6:0]  bits;
		logic [6:0]  total;
		logic [5:0]  len;
		logic [39:0] tx;
		logic        fill;
		logic [31:0] rx;
		logic [31:0] rx_keep;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic        sclk;
		logic        cs_n;
		logic        din;
		logic        in_s1;
		logic        in_s2;
	} state_type;

	state_type q;
	state_type d;
	logic [5:0] new_len;

	assign new_len = reg_len(WDATA_IN[5:0]);

	always_comb begin
		d = q;
		d.in_s1 = link.dout_line;
		d.in_s2 = q.in_s1;
		d.rdata = 32'h0000_0000;
		if (RD_IN) begin
			case (ADDR_IN)
				H_DATA:   d.rdata = q.rx_keep;
				H_STATUS: d.rdata = {30'h0000_0000, q.three_wire, q.busy};
				H_MODE:   d.rdata = {31'h0000_0000, q.three_wire};
				default:  d.rdata = 32'h0000_0000;
			endcase
		end
		if (WR_IN && ADDR_IN == H_DATA) begin
			d.wdata = WDATA_IN;
		end
		if (WR_IN && ADDR_IN == H_MODE) begin
			d.three_wire = WDATA_IN[0]; // see R02
		end
		if (WR_IN && !q.busy && ADDR_IN == H_CTRL) begin
			// command byte leads, data follows msb first
			d.busy = 1'b1; // see R04
			d.cs_n = 1'b0;
			d.div = 8'd0;
			d.bits = 7'd0;
			d.len = new_len;
			d.fill = 1'b0;
			d.total = 7'(CMD_BITS) + 7'(new_len); // see R07 R08
			// read frames send zeros in the data phase
			d.tx = {1'b0, WDATA_IN[CMD_RW_BIT], WDATA_IN[5:0],
				(WDATA_IN[CMD_RW_BIT] ? 32'h0000_0000 : q.wdata) << (6'd32 - new_len)}; // see R13 R14
		end
		if (WR_IN && !q.busy && ADDR_IN == H_RESET) begin
			d.busy = 1'b1; // see R12
			d.cs_n = 1'b0;
			d.div = 8'd0;
			d.bits = 7'd0;
			d.len = 6'd8;
			d.fill = 1'b1;
			d.total = ONES_RESET; // see R10
			d.tx = {40{1'b1}};
		end
		if (q.busy) begin
			d.div = q.div + 8'd1;
			if (q.div == 8'(HALF - 1)) begin
				d.div = 8'd0;
				if (q.sclk && q.bits != q.total) begin
					d.sclk = 1'b0; // see R01
					d.din = q.tx[39];
					d.tx = {q.tx[38:0], q.fill};
				end else if (!q.sclk) begin
					d.sclk = 1'b1; // see R01
					d.rx = {q.rx[30:0], q.in_s2};
					d.bits = q.bits + 7'd1;
				end else begin
					d.busy = 1'b0;
					d.cs_n = ~q.three_wire; // see R02
					d.din = 1'b1;
					d.rx_keep = q.rx & (32'hffff_ffff >> (6'd32 - q.len));
				end
			end
		end else if (!d.busy) begin
			// select idles high with four signals, stays low with three
			d.cs_n = ~q.three_wire; // see R02
		end
	end

	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			q <= '{
				sclk: 1'b1,
				cs_n: 1'b1,
				din: 1'b1,
				len: 6'd8,
				default: '0
			};
		end else begin
			q <= d;
		end
	end

	assign RDATA_OUT = q.rdata;
	assign BUSY_OUT  = q.busy;
	assign link.sclk = q.sclk;
	assign link.cs_n = q.cs_n;
	assign link.din  = q.din;
endmodule

/* src/spi_link_if.sv */
// four-signal serial link between host and device
// assumes a pull-up on the device data output while it is not driven
`timescale 1ns/100ps
interface spi_link_if;
	logic sclk;
	logic cs_n;
	logic din;
	logic dout;
	logic dout_oe;
	logic dout_line;

	assign dout_line = dout_oe ? dout : 1'b1;

	modport dev (
		input  sclk,
		input  cs_n,
		input  din,
		output dout,
		output dout_oe
	);
	modport host (
		output sclk,
		output cs_n,
		output din,
		input  dout_line
	);
endinterface

/* test/spi_link_chk.sv */
// checker for the serial link between host end and device end
// assumes it samples the link on the host clock beside the link interface
`timescale 1ns/100ps
module spi_link_chk (
	input wire logic MCLK_IN,
	input wire logic RESETN_IN,
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe
);
	logic [7:0] cmd_q;
	logic [5:0] cnt_q;
	logic [5:0] len;

	always_comb begin
		case (cmd_q[5:0])
			6'h04: len = 6'h20;
			6'h07, 6'h10, 6'h20: len = 6'h10;
			6'h30: len = 6'h18;
			default: len = 6'h08;
		endcase
	end

	// bit count of the frame; wraps once command and data are through
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			cnt_q <= 6'h00;
			cmd_q <= 8'h00;
		end else if (cs_n) begin
			cnt_q <= 6'h00;
		end else if ($rose(sclk)) begin
			if (cnt_q < 6'h08) begin
				cmd_q <= {cmd_q[6:0], din};
			end
			cnt_q <= (cnt_q >= 6'h08 && cnt_q + 6'h01 == 6'h08 + len) ? 6'h00 : cnt_q + 6'h01;
		end
	end

	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RESETN_IN);

	property p_idle_high; cs_n |-> sclk; endproperty
	a_idle_high: assert property (p_idle_high) else $error("serial clock low while deselected");
	property p_sample; $rose(sclk) |-> $stable(din); endproperty
	a_sample: assert property (p_sample) else $error("data in moved at sample edge");
	property p_drive; $changed(dout) |-> $fell(sclk) || $rose(cs_n); endproperty
	a_drive: assert property (p_drive) else $error("data out moved off the drive edge");
	property p_half; $changed(sclk) |=> $stable(sclk)[*7]; endproperty
	a_half: assert property (p_half) else $error("serial clock half period short");
	property p_oe_start; $rose(dout_oe) |-> cnt_q == 6'h08 && cmd_q[6] && !cmd_q[7]; endproperty
	a_oe_start: assert property (p_oe_start) else $error("drive began off a read command");
	property p_oe_off; cs_n && $past(cs_n) |-> !dout_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
	property p_frame_end; $rose(cs_n) |-> cnt_q == 6'h00; endproperty
	a_frame_end: assert property (p_frame_end) else $error("frame ended mid register");
	property p_oe_end; $fell(dout_oe) |-> cnt_q == 6'h00; endproperty
	a_oe_end: assert property (p_oe_end) else $error("read drive length wrong");

	c_read: cover property ($rose(dout_oe));
	c_frame: cover property ($rose(cs_n));
	c_long: cover property (cnt_q == 6'h27);
endmodule

/* test/spi_register_access_front_end_bench.sv */
// self-checking bench: host end and device end joined by the link
// assumes the default divider, so the serial clock runs at 160 ns
`timescale 1ns/100ps
module spi_register_access_front_end_bench;
	import spi_front_pkg::*;
	localparam logic [15:0] ID = 16'h3cc3; // arbitrary value
	localparam logic [31:0] SMP = 32'hc3a5_0f96;
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  addr = 3'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        busy;
	logic [7:0]  ctl;
	logic [15:0] ch;
	logic [15:0] setup;
	logic [23:0] offs;
	logic [31:0] v;
	int          fails = 0;
	int          checks = 0;
	logic [5:0]  ta [4] = '{ADDR_CTL, ADDR_CH0, ADDR_SETUP0, ADDR_OFFS0};
	logic [31:0] tv [4] = '{32'h0000_005a, 32'h0000_1234, 32'h0000_beef, 32'h00ab_cdef};

	spi_link_if link_i ();
	spi_host_end spi_host_end_i (.MCLK_IN(mclk), .RESETN_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .BUSY_OUT(busy), .link(link_i.host));
	spi_dev_end #(.ID_VALUE(ID)) spi_dev_end_i (.link(link_i.dev), .RESETN_IN(rst_n), .SAMPLE_IN(SMP),
		.CTL_OUT(ctl), .CH_CFG_OUT(ch), .SETUP_OUT(setup), .OFFSET_OUT(offs));
	spi_link_chk spi_link_chk_i (.MCLK_IN(mclk), .RESETN_IN(rst_n), .sclk(link_i.sclk), .cs_n(link_i.cs_n),
		.din(link_i.din), .dout(link_i.dout), .dout_oe(link_i.dout_oe));

	initial begin
		forever #5 mclk = ~mclk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [31:0] d);
		@(posedge mclk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [2:0] a);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		@(posedge mclk);
		v = rdata;
	endtask

	// bounded wait for the frame to finish
	task automatic wait_idle();
		repeat (2) @(negedge mclk);
		for (int n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge mclk);
		if (busy !== 1'b0) begin
			fails++;
			end_sim();
		end
	endtask

	task automatic xfer(input logic [6:0] cmd, input logic [31:0] d);
		wr_reg(H_DATA, d);
		wr_reg(H_CTRL, {25'h0, cmd});
		wait_idle();
		rd_reg(H_DATA);
	endtask

	task automatic chk_defaults();
		chk("ctl", 32'(RST_CTL), 32'(ctl));
		chk("ch0", 32'(RST_CH0), 32'(ch));
		chk("setup0", 32'(RST_SETUP0), 32'(setup));
		chk("offs0", 32'(RST_OFFS0), 32'(offs));
	endtask

	task automatic t_write_read();
		for (int i = 0; i < 4; i++) xfer({1'b0, ta[i]}, tv[i]);
		chk("select idle", 32'h0000_0001, 32'(link_i.cs_n));
		chk("ctl", tv[0], 32'(ctl));
		chk("ch0", tv[1], 32'(ch));
		chk("setup0", tv[2], 32'(setup));
		chk("offs0", tv[3], 32'(offs));
		for (int i = 0; i < 4; i++) begin
			xfer({1'b1, ta[i]}, 32'h0000_0000);
			chk("readback", tv[i], v);
		end
		$display("test write_read done");
	endtask

	task automatic t_fixed();
		xfer({1'b0, ADDR_ID}, 32'h0000_1111);
		xfer({1'b1, ADDR_ID}, 32'h0000_0000);
		chk("id", 32'(ID), v);
		xfer({1'b1, ADDR_SAMPLE}, 32'h0000_0000);
		chk("sample", SMP, v);
		xfer({1'b1, ADDR_CMD}, 32'h0000_0000);
		chk("cmd read", 32'h0000_0000, v);
		$display("test fixed done");
	endtask

	task automatic t_three_wire();
		wr_reg(H_MODE, 32'h0000_0001);
		xfer({1'b0, ADDR_CH0}, 32'h0000_0f0f);
		chk("select held", 32'h0000_0000, 32'(link_i.cs_n));
		xfer({1'b1, ADDR_CH0}, 32'h0000_0000);
		chk("ch0 3w", 32'h0000_0f0f, v);
		rd_reg(H_STATUS);
		chk("status", 32'h0000_0002, v);
		wr_reg(H_MODE, 32'h0000_0000);
		$display("test three_wire done");
	endtask

	task automatic t_soft_reset();
		wr_reg(H_RESET, 32'h0000_0000);
		wait_idle();
		chk_defaults();
		xfer({1'b1, ADDR_ID}, 32'h0000_0000);
		chk("id after", 32'(ID), v);
		$display("test soft_reset done");
	endtask

	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		chk_defaults();
		$display("test defaults done");
		t_write_read();
		t_fixed();
		t_three_wire();
		t_soft_reset();
		end_sim();
	end
endmodule
